/* src/scsp_pkg.sv */
// package: constants and types of the serial command and status port
package scsp_pkg;
    localparam int unsigned FRAME_BITS = 16;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_LAST = 4'hf;
    // register addresses within a bank
    localparam logic [2:0] ADDR_STAT_READ = 3'h0;
    localparam logic [2:0] ADDR_FAULT = 3'h1;
    localparam logic [2:0] ADDR_GEN_CFG = 3'h6;
    localparam logic [2:0] ADDR_DIAG = 3'h7;
    // reset values
    localparam logic [9:0] CFG_RST = 10'h000;
    localparam logic [3:0] SOA_RST = 4'h0;
    // synchroniser vector bit positions
    localparam int unsigned SY_SCLK = 0;
    localparam int unsigned SY_CS = 1;
    localparam int unsigned SY_SDI = 2;
    localparam int unsigned SY_RPIN = 3;
    localparam int unsigned SY_HOT = 4;
    localparam int unsigned SY_NM = 5;
    localparam int unsigned SY_ON0 = 6;
    localparam logic [7:0] SYNC_RST = 8'h02;

    // one received or returned 16-bit frame
    typedef struct packed {
        logic wd_toggle;
        logic parity;
        logic bank;
        logic [2:0] addr;
        logic [9:0] payload;
    } scsp_frame_t;

    // sixteen payload slots indexed by {bank, addr}
    typedef logic [15:0][9:0] scsp_cfg_t;

    typedef enum logic [0:0] {
        SCSP_IDLE = 1'b0,
        SCSP_SHIFT = 1'b1
    } scsp_state_t;
endpackage

/* src/scsp_port.sv */
// serial command and status port of a dual-channel high-side switch
// Operation
// - frames travel msb first, bit 15 down to bit 0, in and out
// - serial traffic has effect only while the reset pin is high
// - bit 14 gives even parity; every received word is checked
// - frame bit 13 selects register bank 0 or bank 1
// - frame bits 12..10 address the register within the bank
// - low ten bits are payload; status read uses them to pick a word
// - several frames may follow within one select low period
// - select rise discards transfer on bad length or parity error
// - fourteen writable input registers and sixteen readable words
// - after select falls, output bits go out msb first while input shifts
// - first output word is the one chosen by the last status read
// - select rise checks length and parity, then latches the frame
// - after latch the output floats and status is refreshed
// - input reappears on the output one 16-bit frame later
// - normal mode sets overtemp warning at bit 8 without switching off
// - warning clears only on a fault read while already cool
// - status bits 0 and 1 report each channel's live on state
`timescale 1ns/100ps
`default_nettype none
module scsp_port (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic active_low_reset_pin_b,
    input wire logic chip_select_low_b,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic temp_above_warn,
    input wire logic normal_mode,
    input wire logic [1:0] chan_on,
    output logic sdo,
    output logic sdo_oe,
    output var scsp_pkg::scsp_cfg_t cfg_regs,
    output logic watchdog_toggle_bit,
    output logic overtemp_warning_flag,
    output logic parity_fault,
    output logic frame_latched
);
    logic [7:0] sy1_q;
    logic [7:0] sy2_q;
    logic [1:0] sy3_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic rpin;
    logic hot;
    logic nm;
    scsp_pkg::scsp_state_t st_q, st_d;
    scsp_pkg::scsp_frame_t shift_q, shift_d;
    scsp_pkg::scsp_frame_t out_word;
    scsp_pkg::scsp_cfg_t cfg_q, cfg_d;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] soa_q, soa_d;
    logic par_q, par_d;
    logic perr_q, perr_d;
    logic any_q, any_d;
    logic sdo_q, sdo_d;
    logic oe_q, oe_d;
    logic wdt_q, wdt_d;
    logic pf_q, pf_d;
    logic warn_q, warn_d;
    logic latch_q, latch_d;
    logic par_n;
    logic warn_clr;

    // two-flop synchronisers for every pin, third stage for edge finding
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sy1_q <= scsp_pkg::SYNC_RST;
            sy2_q <= scsp_pkg::SYNC_RST;
            sy3_q <= scsp_pkg::SYNC_RST[1:0];
        end else begin
            sy1_q <= {chan_on, normal_mode, temp_above_warn, active_low_reset_pin_b,
                      sdi, chip_select_low_b, sclk};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q[1:0];
        end
    end

    // edges and levels seen by the port logic
    assign sclk_rise = sy2_q[scsp_pkg::SY_SCLK] & ~sy3_q[scsp_pkg::SY_SCLK];
    assign sclk_fall = ~sy2_q[scsp_pkg::SY_SCLK] & sy3_q[scsp_pkg::SY_SCLK];
    assign cs_fall = ~sy2_q[scsp_pkg::SY_CS] & sy3_q[scsp_pkg::SY_CS];
    assign cs_rise = sy2_q[scsp_pkg::SY_CS] & ~sy3_q[scsp_pkg::SY_CS];
    assign rpin = sy2_q[scsp_pkg::SY_RPIN];
    assign hot = sy2_q[scsp_pkg::SY_HOT];
    assign nm = sy2_q[scsp_pkg::SY_NM];

    // returned word chosen by the last status read command
    always_comb begin
        out_word.wd_toggle = wdt_q;
        out_word.parity = pf_q;
        {out_word.bank, out_word.addr} = soa_q;
        out_word.payload = {nm, 9'h000};
        unique case (soa_q[2:0])
            scsp_pkg::ADDR_STAT_READ: out_word.payload[1:0] = sy2_q[7:6];
            scsp_pkg::ADDR_FAULT: out_word.payload[8] = warn_q;
            scsp_pkg::ADDR_DIAG: out_word.payload[8:0] = 9'h000;
            scsp_pkg::ADDR_GEN_CFG: out_word.payload[8:0] = cfg_q[{1'b0, soa_q[2:0]}][8:0];
            default: out_word.payload[8:0] = cfg_q[soa_q][8:0];
        endcase
    end

    // next state of the serial engine and the register file
    always_comb begin
        st_d = st_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        par_d = par_q;
        perr_d = perr_q;
        any_d = any_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        cfg_d = cfg_q;
        soa_d = soa_q;
        wdt_d = wdt_q;
        pf_d = pf_q;
        latch_d = 1'b0;
        warn_clr = 1'b0;
        par_n = par_q ^ sy2_q[scsp_pkg::SY_SDI];
        if (!rpin) begin
            // reset pin low: port idle, registers back to reset values
            st_d = scsp_pkg::SCSP_IDLE;
            oe_d = 1'b0;
            cfg_d = {16{scsp_pkg::CFG_RST}};
            soa_d = scsp_pkg::SOA_RST;
            wdt_d = 1'b0;
        end else begin
            unique case (st_q)
                scsp_pkg::SCSP_IDLE: begin
                    if (cs_fall) begin
                        st_d = scsp_pkg::SCSP_SHIFT;
                        shift_d = out_word;
                        sdo_d = out_word.wd_toggle;
                        oe_d = 1'b1;
                        cnt_d = scsp_pkg::CNT_RST;
                        par_d = 1'b0;
                        perr_d = 1'b0;
                        any_d = 1'b0;
                        warn_clr = (soa_q[2:0] == scsp_pkg::ADDR_FAULT) && !hot;
                    end
                end
                scsp_pkg::SCSP_SHIFT: begin
                    if (cs_rise) begin
                        st_d = scsp_pkg::SCSP_IDLE;
                        oe_d = 1'b0;
                        pf_d = perr_q;
                        if (any_q && cnt_q == scsp_pkg::CNT_RST && !perr_q) begin
                            latch_d = 1'b1;
                            wdt_d = shift_q.wd_toggle;
                            if (shift_q.addr == scsp_pkg::ADDR_STAT_READ) begin
                                soa_d = {shift_q.bank, shift_q.payload[2:0]};
                            end else begin
                                cfg_d[{shift_q.bank, shift_q.addr}] = shift_q.payload;
                            end
                        end
                    end else begin
                        if (sclk_rise) begin
                            // sample on rising edge; old msb leaves, new bit enters lsb
                            shift_d = {shift_q[14:0], sy2_q[scsp_pkg::SY_SDI]};
                            cnt_d = cnt_q + 4'h1;
                            any_d = 1'b1;
                            if (cnt_q == scsp_pkg::CNT_LAST) begin
                                par_d = 1'b0;
                                perr_d = perr_q | par_n;
                            end else begin
                                par_d = par_n;
                            end
                        end
                        if (sclk_fall) begin
                            sdo_d = shift_q[15];
                        end
                    end
                end
            endcase
        end
        // set wins over clear
        warn_d = (warn_q & ~warn_clr) | (hot & nm);
    end

    // register stage of the serial engine
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= scsp_pkg::SCSP_IDLE;
            shift_q <= '0;
            cnt_q <= scsp_pkg::CNT_RST;
            par_q <= 1'b0;
            perr_q <= 1'b0;
            any_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            cfg_q <= {16{scsp_pkg::CFG_RST}};
            soa_q <= scsp_pkg::SOA_RST;
            wdt_q <= 1'b0;
            pf_q <= 1'b0;
            warn_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            st_q <= st_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            par_q <= par_d;
            perr_q <= perr_d;
            any_q <= any_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            cfg_q <= cfg_d;
            soa_q <= soa_d;
            wdt_q <= wdt_d;
            pf_q <= pf_d;
            warn_q <= warn_d;
            latch_q <= latch_d;
        end
    end

    // outputs straight from flops
    assign sdo = sdo_q;
    assign sdo_oe = oe_q;
    assign cfg_regs = cfg_q;
    assign watchdog_toggle_bit = wdt_q;
    assign overtemp_warning_flag = warn_q;
    assign parity_fault = pf_q;
    assign frame_latched = latch_q;

    // checks on the engine
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_end_shift;
        rpin && st_q == scsp_pkg::SCSP_SHIFT && cs_rise;
    endsequence
    sequence s_start_load;
        rpin && st_q == scsp_pkg::SCSP_IDLE && cs_fall;
    endsequence
    // select rise after a whole number of words with good parity
    sequence s_good_end;
        s_end_shift ##0 (any_q && cnt_q == scsp_pkg::CNT_RST && !perr_q);
    endsequence
    // select fall that starts a fault word read
    sequence s_fault_read;
        s_start_load ##0 soa_q[2:0] == scsp_pkg::ADDR_FAULT;
    endsequence

    a_oe_idle: assert property (st_q == scsp_pkg::SCSP_IDLE |-> !oe_q)
        else $error("serial output driven while idle");
    a_shift_msb: assert property (rpin && st_q == scsp_pkg::SCSP_SHIFT
        && sclk_rise && !cs_rise
        |=> shift_q[0] == $past(sy2_q[scsp_pkg::SY_SDI])
            && shift_q[15:1] == $past(shift_q[14:0]))
        else $error("input bit not shifted in msb first");
    a_bad_len: assert property (s_end_shift ##0 cnt_q != scsp_pkg::CNT_RST |=> !latch_q)
        else $error("frame of wrong length latched");
    a_parity_drop: assert property (s_end_shift ##0 perr_q |=> !latch_q && pf_q)
        else $error("frame with parity error latched");
    a_good_latch: assert property (s_good_end |=> latch_q
        && ($past(shift_q.addr) == scsp_pkg::ADDR_STAT_READ
            || cfg_q[{$past(shift_q.bank), $past(shift_q.addr)}] == $past(shift_q.payload)))
        else $error("valid frame not latched into its register");
    a_reset_pin: assert property (!rpin |=> st_q == scsp_pkg::SCSP_IDLE && !latch_q)
        else $error("port active while reset pin low");
    a_load_word: assert property (s_start_load |=> shift_q == $past(out_word) && oe_q
        && sdo_q == shift_q[15])
        else $error("wrong first output word");
    a_keep_shift: assert property (rpin && st_q == scsp_pkg::SCSP_SHIFT && !cs_rise
        ##1 rpin |-> st_q == scsp_pkg::SCSP_SHIFT)
        else $error("shifting stopped while select low");
    a_sdo_fall: assert property (rpin && st_q == scsp_pkg::SCSP_SHIFT && sclk_fall
        && !cs_rise |=> sdo_q == $past(shift_q[15]))
        else $error("output bit not from frame one word back");

    // warning flag: set while hot in normal mode, cleared only by a cool read
    a_warn_set: assert property (hot && nm |=> warn_q [*1] ##0 overtemp_warning_flag)
        else $error("overtemp warning not set");
    a_warn_hold: assert property (warn_q && hot |=> warn_q)
        else $error("overtemp warning cleared while hot");
    a_warn_clear: assert property (s_fault_read ##0 !hot |=> !warn_q)
        else $error("warning not cleared by a cool fault read");
    a_warn_keep: assert property (warn_q && !cs_fall |=> warn_q)
        else $error("warning cleared without a read");
    a_chan_on: assert property (s_start_load ##0 soa_q[2:0] == 3'h0
        |=> shift_q[1:0] == $past(sy2_q[7:6]))
        else $error("channel on state not reported");

    // one pulse per accepted frame; registers move only on an accepted frame or while the reset pin is low
    a_latch_pulse: assert property (latch_q |=> !latch_q)
        else $error("latch pulse longer than one cycle");
    a_cfg_hold: assert property (rpin && !(st_q == scsp_pkg::SCSP_SHIFT && cs_rise)
        |=> $stable(cfg_q))
        else $error("register changed without an accepted frame");
    a_pf_update: assert property (s_end_shift |=> pf_q == $past(perr_q))
        else $error("parity fault not updated at select rise");
    a_wd_latch: assert property (s_good_end
        |=> watchdog_toggle_bit == $past(shift_q.wd_toggle))
        else $error("watchdog bit not taken from the accepted frame");
    a_sel_store: assert property (s_good_end ##0 shift_q.addr == scsp_pkg::ADDR_STAT_READ
        |=> soa_q == {$past(shift_q.bank), $past(shift_q.payload[2:0])})
        else $error("status read did not store its word select");
endmodule // scsp_port
`default_nettype wire

/* tb/scsp_master.sv */
// partner model: serial bus master that clocks frames through the port
`timescale 1ns/100ps
`default_nettype none
module scsp_master (
    input wire logic clk_sys,
    output logic cs_b,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // idle lines: select high, clock parked low
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // wait n system clocks, then move just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one select-low period of nbits, return bits taken before each rise
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = '0;
        tick(1);
        cs_b = 1'b0;
        tick(6);
        // msb first, frames may run back to back while select stays low
        for (int i = nbits - 1; i >= 0; i--) begin
            sdi = tx[i];
            tick(4);
            sclk = 1'b1; // device samples on the rise
            rx = {rx[30:0], sdo_oe ? sdo : 1'bx};
            tick(4);
            sclk = 1'b0;
        end
        tick(4);
        cs_b = 1'b1;
        sdi = ~sdi; // released data line must not keep showing the last bit
        tick(8);
    endtask
endmodule // scsp_master
`default_nettype wire

/* tb/testbench.sv */
// testbench: frame level checks of the serial command and status port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic pin_b = 1'b1;
    logic hot = 1'b0;
    logic nm = 1'b1;
    logic [1:0] chan_on = 2'h2;
    logic cs_b, sclk, sdi, sdo, sdo_oe, wd_bit, ot_flag, pf, fl;
    scsp_pkg::scsp_cfg_t cfg;
    int n_fail = 0;
    int checked = 0;
    int n_latch = 0;
    int l0;
    logic wd = 1'b0;
    logic wl = 1'b0;
    logic [31:0] rx;

    always #5 clk_sys = ~clk_sys;
    // count latch pulses away from the launching edge
    always @(negedge clk_sys) if (fl === 1'b1) n_latch++;

    scsp_master i_master (.clk_sys(clk_sys), .cs_b(cs_b), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe));
    scsp_port i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .active_low_reset_pin_b(pin_b),
        .chip_select_low_b(cs_b), .sclk(sclk), .sdi(sdi), .temp_above_warn(hot),
        .normal_mode(nm), .chan_on(chan_on), .sdo(sdo), .sdo_oe(sdo_oe), .cfg_regs(cfg),
        .watchdog_toggle_bit(wd_bit), .overtemp_warning_flag(ot_flag),
        .parity_fault(pf), .frame_latched(fl));

    // closing report and verdict
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // compare one value
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // frame with the given watchdog bit and even parity in bit 14
    function automatic logic [15:0] mk(input logic w, input logic b, input logic [2:0] a,
        input logic [9:0] p);
        return {w, ^{w, b, a, p}, b, a, p};
    endfunction

    // one good 16-bit frame
    task automatic run1(input logic b, input logic [2:0] a, input logic [9:0] p);
        wd = ~wd;
        i_master.xfer({16'h0000, mk(wd, b, a, p)}, 16, rx);
        wl = wd;
    endtask

    // bound on the whole run
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        i_master.tick(4);
        // write bank 1 slot 2, then check latch and floating output
        l0 = n_latch;
        run1(1'b1, 3'h2, 10'h2a5);
        check({6'h00, cfg[10]}, 16'h02a5, "bank1 slot2");
        check(16'(n_latch - l0), 16'h0001, "one latch");
        check({15'h0000, sdo_oe}, 16'h0000, "sdo floats");
        check({15'h0000, wd_bit}, {15'h0000, wl}, "watchdog bit");
        // select bank 1 word 2, then device status word
        run1(1'b1, 3'h0, 10'h002);
        run1(1'b0, 3'h0, 10'h000);
        check(rx[15:0], {~wl, 1'b0, 4'ha, 1'b1, 9'h0a5}, "selected word");
        run1(1'b0, 3'h0, 10'h000);
        check(rx[15:0], {~wl, 1'b0, 4'h0, 1'b1, 9'h002}, "status on bits");
        // parity error: nothing latched
        l0 = n_latch;
        i_master.xfer({16'h0000, mk(1'b1, 1'b1, 3'h2, 10'h2a5) ^ 16'h0001}, 16, rx);
        check(16'(n_latch - l0), 16'h0000, "parity refused");
        check({15'h0000, pf}, 16'h0001, "parity fault");
        // short frame: nothing latched
        i_master.xfer({16'h0000, mk(1'b0, 1'b1, 3'h2, 10'h111)}, 15, rx);
        check(16'(n_latch - l0), 16'h0000, "length refused");
        check({15'h0000, pf}, 16'h0000, "parity cleared");
        check({6'h00, cfg[10]}, 16'h02a5, "slot kept");
        // two frames in one select: delayed echo, last one latched
        l0 = n_latch;
        i_master.xfer({mk(1'b1, 1'b1, 3'h2, 10'h11b), mk(1'b0, 1'b1, 3'h3, 10'h0c3)}, 32, rx);
        check(rx[15:0], mk(1'b1, 1'b1, 3'h2, 10'h11b), "daisy echo");
        check({6'h00, cfg[11]}, 16'h00c3, "last frame");
        check({6'h00, cfg[10]}, 16'h02a5, "first frame");
        check(16'(n_latch - l0), 16'h0001, "single latch");
        wl = 1'b0;
        wd = 1'b0;
        // overtemp warning sets, stays while hot, clears on a cool read
        hot = 1'b1;
        i_master.tick(10);
        check({15'h0000, ot_flag}, 16'h0001, "warning set");
        run1(1'b0, 3'h0, 10'h001);
        run1(1'b0, 3'h0, 10'h001);
        check(rx[15:0], {~wl, 1'b0, 4'h1, 1'b1, 9'h100}, "fault word");
        check({15'h0000, ot_flag}, 16'h0001, "kept while hot");
        hot = 1'b0;
        i_master.tick(10);
        check({15'h0000, ot_flag}, 16'h0001, "kept until read");
        run1(1'b0, 3'h0, 10'h001);
        check({15'h0000, ot_flag}, 16'h0000, "cleared by read");
        // reset pin low: frames ignored
        pin_b = 1'b0;
        i_master.tick(4);
        l0 = n_latch;
        run1(1'b1, 3'h2, 10'h155);
        check(16'(n_latch - l0), 16'h0000, "reset pin");
        check({6'h00, cfg[10]}, 16'h0000, "cfg cleared");
        pin_b = 1'b1;
        i_master.tick(4);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
